// file: common/cas_pkg.sv
// Shared constants and types for the CPU ALU status datapath.
package cas_pkg;
  localparam int DATA_W = 16;
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CONTROL = 2'h1;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] STATUS_SW_MASK = 16'h010f;
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_WRAP = 2;
  localparam int ST_NEG = 3;
  localparam int ST_LOOP = 4;
  localparam int ST_PRIO_LSB = 5;
  localparam int ST_HALF = 8;
  localparam int CT_PSV = 2;
  localparam int CT_TOP = 3;
  localparam logic [2:0] PRIO_ALL = 3'h7;
  localparam logic [4:0] DIV_CYCLES = 5'h13;
  localparam logic [4:0] DIV_BITS = 5'h10;
  localparam logic [22:0] PC_STEP = 23'h000002;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADDC = 4'h1,
    OP_SUB = 4'h2,
    OP_SUBB = 4'h3,
    OP_AND = 4'h4,
    OP_IOR = 4'h5,
    OP_XOR = 4'h6,
    OP_ASR = 4'h7,
    OP_LSR = 4'h8,
    OP_SL = 4'h9,
    OP_MUL = 4'ha
  } cas_op_t;

  typedef enum logic [1:0] {
    AS_PC = 2'h0,
    AS_TABLE = 2'h1,
    AS_WINDOW = 2'h2
  } cas_asel_t;

  typedef enum logic {
    DV_IDLE = 1'b0,
    DV_RUN = 1'b1
  } cas_div_st_t;
endpackage

// file: logic/cas_datapath.sv
// CPU ALU datapath with status and control registers, multiplier and divider.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module cas_datapath (
  input wire logic i_sys_clk, // Core clock, 10 MHz
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic i_clk_en, // Freezes all state when low
  input wire logic [1:0] i_reg_addr, // Register index
  input wire logic [15:0] i_reg_wdata, // Register write data
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  output logic [15:0] o_reg_rdata, // Read data, one cycle later
  input wire logic i_op_valid, // ALU operation strobe
  input wire cas_pkg::cas_op_t i_op_code, // ALU operation
  input wire logic i_op_byte, // Byte size when high
  input wire logic i_mul_a_signed, // Operand a is signed
  input wire logic i_mul_b_signed, // Operand b is signed
  input wire logic [15:0] i_op_a, // Operand a
  input wire logic [15:0] i_op_b, // Operand b or shift count
  output logic [15:0] o_result, // ALU result
  output logic [31:0] o_product, // Multiplier product
  output logic o_result_valid, // Result pulse
  input wire logic i_loop_active, // Repeat loop running
  input wire logic i_nesting_disable, // Nesting disable control
  input wire logic i_prio_load, // Interrupt logic loads priority
  input wire logic [3:0] i_prio_value, // Priority value to load
  input wire logic i_prio_top_set, // Raise the top priority bit
  output logic [15:0] o_status, // Status register
  output logic [15:0] o_control, // Control register
  output logic [3:0] o_cpu_priority, // Current CPU priority
  output logic o_user_irq_block, // User interrupts blocked
  output logic o_prog_window_enable, // Program space window on
  input wire logic i_div_start, // Start a divide
  input wire logic i_div_signed, // Signed divide
  input wire logic i_div_long, // 32-bit dividend
  input wire logic i_div_suspend, // Pause the divide
  input wire logic [15:0] i_div_hi, // Dividend high word
  input wire logic [15:0] i_div_lo, // Dividend low word
  input wire logic [15:0] i_divisor, // Divisor
  output logic [15:0] o_work_reg_zero, // Quotient
  output logic [15:0] o_work_reg_one, // Remainder
  output logic o_div_busy, // Divide running
  output logic o_div_done, // Divide done pulse
  input wire logic i_pc_load, // Load program counter
  input wire logic i_pc_step, // Step program counter
  input wire logic [22:0] i_pc_value, // New program counter
  input wire cas_pkg::cas_asel_t i_addr_sel, // Address source
  input wire logic [7:0] i_table_page, // Table page register
  input wire logic [15:0] i_table_offset, // Table offset
  input wire logic [7:0] i_window_page, // Window page
  input wire logic [15:0] i_data_ea, // Data effective address
  output logic [23:0] o_prog_addr, // Program space address
  output logic o_window_hit, // Data access mapped to program
  output logic o_config_space // Address in configuration half
);
  import cas_pkg::*;

  typedef struct packed {
    logic [15:0] status;
    logic [15:0] control;
    logic [15:0] rdata;
    logic [15:0] result;
    logic [31:0] product;
    logic res_valid;
    logic irq_block;
    cas_div_st_t div_st;
    logic [4:0] div_cnt;
    logic [15:0] div_rem;
    logic [15:0] div_quo;
    logic [15:0] div_dsr;
    logic div_neg_q;
    logic div_neg_r;
    logic [15:0] quot;
    logic [15:0] rem;
    logic div_done;
    logic [22:0] pc;
    logic [23:0] paddr;
    logic win_hit;
    logic cfg;
  } cas_state_t;

  cas_state_t r_ff;
  cas_state_t nxt_r;

  logic is_sub;
  logic cin;
  logic [15:0] b_eff;
  logic [8:0] lo_sum;
  logic [4:0] nib_sum;
  logic [16:0] wd_sum;
  logic [15:0] ext_a;
  logic [15:0] alu_res;
  logic [15:0] sh_res;
  logic msb_a;
  logic msb_b;
  logic msb_r;
  logic [16:0] mul_a;
  logic [16:0] mul_b;
  logic [33:0] mul_p;
  logic [31:0] dd;
  logic [31:0] dd_abs;
  logic [15:0] ds_abs;
  logic [16:0] div_sh;
  logic div_ge;

  always_comb begin
    is_sub = (i_op_code == OP_SUB) || (i_op_code == OP_SUBB);
    unique case (i_op_code)
      OP_SUB: cin = 1'b1;
      OP_ADDC, OP_SUBB: cin = r_ff.status[ST_CARRY];
      default: cin = 1'b0;
    endcase
    // Adding the inverted operand plus one leaves carry high on no borrow.
    b_eff = is_sub ? ~i_op_b : i_op_b;
    lo_sum = {1'b0, i_op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
    nib_sum = {1'b0, i_op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    wd_sum = {1'b0, i_op_a} + {1'b0, b_eff} + {16'h0000, cin};
    ext_a = i_op_byte ? {{8{i_op_a[7]}}, i_op_a[7:0]} : i_op_a;
    unique case (i_op_code)
      OP_ASR: sh_res = 16'($signed(ext_a) >>> i_op_b[3:0]);
      OP_LSR: sh_res = (i_op_byte ? {8'h00, i_op_a[7:0]} : i_op_a) >> i_op_b[3:0];
      default: sh_res = i_op_a << i_op_b[3:0];
    endcase
    unique case (i_op_code)
      OP_AND: alu_res = i_op_a & i_op_b;
      OP_IOR: alu_res = i_op_a | i_op_b;
      OP_XOR: alu_res = i_op_a ^ i_op_b;
      OP_ASR, OP_LSR, OP_SL: alu_res = sh_res;
      default: alu_res = i_op_byte ? {8'h00, lo_sum[7:0]} : wd_sum[15:0];
    endcase
    if (i_op_byte) begin
      alu_res = {i_op_a[15:8], alu_res[7:0]};
    end
    msb_a = i_op_byte ? i_op_a[7] : i_op_a[15];
    msb_b = i_op_byte ? b_eff[7] : b_eff[15];
    msb_r = i_op_byte ? alu_res[7] : alu_res[15];
    // One 17x17 signed multiplier serves every sign mix; the upper byte is
    // masked for 8x8 and the sequencer zero-extends a 5-bit literal.
    mul_a = {i_mul_a_signed & i_op_a[15], i_op_a};
    mul_b = {i_mul_b_signed & i_op_b[15], i_op_b};
    if (i_op_byte) begin
      mul_a = {9'h000, i_op_a[7:0]};
      mul_b = {9'h000, i_op_b[7:0]};
    end
    mul_p = 34'($signed(mul_a) * $signed(mul_b));
    dd = i_div_long ? {i_div_hi, i_div_lo} :
      {{16{i_div_signed & i_div_lo[15]}}, i_div_lo};
    dd_abs = (i_div_signed && dd[31]) ? 32'(-dd) : dd;
    ds_abs = (i_div_signed && i_divisor[15]) ? 16'(-i_divisor) : i_divisor;
    div_sh = {r_ff.div_rem, r_ff.div_quo[15]};
    div_ge = div_sh >= {1'b0, r_ff.div_dsr};
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.res_valid = 1'b0;
    nxt_r.div_done = 1'b0;
    // Software writes come first so that hardware events override them.
    if (i_reg_wr && i_reg_addr == REG_STATUS) begin
      nxt_r.status = (r_ff.status & ~STATUS_SW_MASK) | (i_reg_wdata & STATUS_SW_MASK);
      if (!i_nesting_disable) begin
        nxt_r.status[7:5] = i_reg_wdata[7:5];
      end
    end
    if (i_reg_wr && i_reg_addr == REG_CONTROL) begin
      nxt_r.control[CT_PSV] = i_reg_wdata[CT_PSV];
      if (!i_reg_wdata[CT_TOP]) begin
        nxt_r.control[CT_TOP] = 1'b0;
      end
    end
    if (i_prio_load) begin
      nxt_r.status[7:5] = i_prio_value[2:0];
      nxt_r.control[CT_TOP] = i_prio_value[3];
    end
    if (i_prio_top_set) begin
      nxt_r.control[CT_TOP] = 1'b1;
    end
    nxt_r.status[ST_LOOP] = i_loop_active;
    nxt_r.status[15:9] = 7'h00;
    nxt_r.control[15:4] = 12'h000;
    nxt_r.control[1:0] = 2'h0;
    // Flags outside an operation's set keep their value.
    if (i_op_valid) begin
      nxt_r.res_valid = 1'b1;
      nxt_r.result = alu_res;
      unique case (i_op_code)
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
          nxt_r.status[ST_CARRY] = i_op_byte ? lo_sum[8] : wd_sum[16];
          nxt_r.status[ST_HALF] = i_op_byte ? nib_sum[4] : lo_sum[8];
          nxt_r.status[ST_WRAP] = (msb_a == msb_b) && (msb_r != msb_a);
        end
        OP_ASR, OP_LSR: begin
          nxt_r.status[ST_CARRY] = (i_op_b[3:0] == 4'h1) ? i_op_a[0] : r_ff.status[ST_CARRY];
        end
        OP_SL: begin
          nxt_r.status[ST_CARRY] = (i_op_b[3:0] == 4'h1) ? msb_a : r_ff.status[ST_CARRY];
        end
        OP_MUL: begin
          nxt_r.product = mul_p[31:0];
          nxt_r.result = mul_p[15:0];
        end
        default: begin
        end
      endcase
      if (i_op_code != OP_MUL) begin
        nxt_r.status[ST_NEG] = msb_r;
        // Carry-chained forms only clear zero so multiword tests work.
        if (i_op_code == OP_ADDC || i_op_code == OP_SUBB) begin
          if ((i_op_byte ? alu_res[7:0] : alu_res) != 16'h0000) begin
            nxt_r.status[ST_ZERO] = 1'b0;
          end
        end else begin
          nxt_r.status[ST_ZERO] = (i_op_byte ? alu_res[7:0] : alu_res) == 16'h0000;
        end
      end
    end
    nxt_r.irq_block = nxt_r.control[CT_TOP] || (nxt_r.status[7:5] == PRIO_ALL);
    nxt_r.rdata = 16'h0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_STATUS: nxt_r.rdata = r_ff.status;
        REG_CONTROL: nxt_r.rdata = r_ff.control;
        default: nxt_r.rdata = 16'h0000;
      endcase
    end
    // Suspending holds the divide state so an interrupt can run in between.
    unique case (r_ff.div_st)
      DV_IDLE: begin
        if (i_div_start) begin
          nxt_r.div_st = DV_RUN;
          nxt_r.div_cnt = 5'h00;
          nxt_r.div_rem = dd_abs[31:16];
          nxt_r.div_quo = dd_abs[15:0];
          nxt_r.div_dsr = ds_abs;
          nxt_r.div_neg_q = i_div_signed && (dd[31] ^ i_divisor[15]);
          nxt_r.div_neg_r = i_div_signed && dd[31];
        end
      end
      DV_RUN: begin
        if (!i_div_suspend) begin
          nxt_r.div_cnt = r_ff.div_cnt + 5'h01;
          if (r_ff.div_cnt < DIV_BITS) begin
            nxt_r.div_rem = div_ge ? 16'(div_sh - {1'b0, r_ff.div_dsr}) : div_sh[15:0];
            nxt_r.div_quo = {r_ff.div_quo[14:0], div_ge};
          end else if (r_ff.div_cnt == DIV_BITS) begin
            nxt_r.div_quo = r_ff.div_neg_q ? 16'(-r_ff.div_quo) : r_ff.div_quo;
            nxt_r.div_rem = r_ff.div_neg_r ? 16'(-r_ff.div_rem) : r_ff.div_rem;
          end
          if (r_ff.div_cnt == DIV_CYCLES - 5'h01) begin
            nxt_r.div_st = DV_IDLE;
            nxt_r.div_done = 1'b1;
            nxt_r.quot = r_ff.div_quo;
            nxt_r.rem = r_ff.div_rem;
          end
        end
      end
    endcase
    if (i_pc_load) begin
      nxt_r.pc = i_pc_value;
    end else if (i_pc_step) begin
      nxt_r.pc = r_ff.pc + PC_STEP;
    end
    nxt_r.win_hit = 1'b0;
    nxt_r.cfg = 1'b0;
    unique case (i_addr_sel)
      AS_TABLE: begin
        // Only a paged table access may reach the configuration half.
        nxt_r.paddr = {i_table_page, i_table_offset};
        nxt_r.cfg = i_table_page[7];
      end
      AS_WINDOW: begin
        nxt_r.win_hit = r_ff.control[CT_PSV] && i_data_ea[15];
        nxt_r.paddr = nxt_r.win_hit ? {1'b0, i_window_page, i_data_ea[14:0]} : 24'h000000;
      end
      default: nxt_r.paddr = {1'b0, r_ff.pc};
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      r_ff <= '0;
      r_ff.status <= STATUS_RST;
      r_ff.control <= CONTROL_RST;
    end else if (i_clk_en) begin
      r_ff <= nxt_r;
    end
  end

  assign o_reg_rdata = r_ff.rdata;
  assign o_result = r_ff.result;
  assign o_product = r_ff.product;
  assign o_result_valid = r_ff.res_valid;
  assign o_status = r_ff.status;
  assign o_control = r_ff.control;
  assign o_cpu_priority = {r_ff.control[CT_TOP], r_ff.status[7:5]};
  assign o_user_irq_block = r_ff.irq_block;
  assign o_prog_window_enable = r_ff.control[CT_PSV];
  assign o_work_reg_zero = r_ff.quot;
  assign o_work_reg_one = r_ff.rem;
  assign o_div_busy = r_ff.div_st == DV_RUN;
  assign o_div_done = r_ff.div_done;
  assign o_prog_addr = r_ff.paddr;
  assign o_window_hit = r_ff.win_hit;
  assign o_config_space = r_ff.cfg;

  // Counts active cycles of a divide independently of the divider counter.
  logic [5:0] chk_div_cnt;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      chk_div_cnt <= 6'h00;
    end else if (i_clk_en) begin
      if (i_div_start && !o_div_busy) begin
        chk_div_cnt <= 6'h00;
      end else if (o_div_busy && !i_div_suspend) begin
        chk_div_cnt <= chk_div_cnt + 6'h01;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_div_cycle_count: assert property ($rose(o_div_done) |-> chk_div_cnt == 6'h13)
    else $error("divide did not take 19 cycles");
  a_irq_block_level: assert property (o_user_irq_block ==
    (o_cpu_priority[3] || o_cpu_priority[2:0] == 3'h7))
    else $error("interrupt block does not match priority");
  a_prio_locked: assert property (i_clk_en && i_reg_wr && i_reg_addr == REG_STATUS &&
    i_nesting_disable && !i_prio_load |=> $stable(o_status[7:5]))
    else $error("priority bits written while nesting disabled");
  a_top_no_set: assert property (i_clk_en && !o_control[3] && !i_prio_top_set &&
    !i_prio_load |=> !o_control[3])
    else $error("software set the top priority bit");
  a_reserved_zero: assert property (i_clk_en && i_reg_rd |=> o_reg_rdata[15:9] == 7'h00)
    else $error("reserved status bits read nonzero");
  a_loop_flag: assert property (i_clk_en |=> o_status[4] == $past(i_loop_active))
    else $error("loop running flag does not follow loop");
  a_sub_no_borrow: assert property (i_clk_en && i_op_valid && i_op_code == OP_SUB &&
    !i_op_byte && i_op_a >= i_op_b |=> o_status[0] && o_result == $past(i_op_a - i_op_b))
    else $error("subtract carry not an inverted borrow");
  a_zero_flag: assert property (i_clk_en && i_op_valid && i_op_code == OP_AND &&
    !i_op_byte |=> o_status[1] == ($past(i_op_a & i_op_b) == 16'h0000))
    else $error("zero flag wrong after logic op");
  a_window_gate: assert property (i_clk_en && i_addr_sel == AS_WINDOW &&
    !o_control[2] |=> !o_window_hit)
    else $error("window mapped while disabled");
  a_mul_unsigned: assert property (i_clk_en && i_op_valid && i_op_code == OP_MUL &&
    i_op_byte |=> o_product == 32'($past(i_op_a[7:0]) * $past(i_op_b[7:0])))
    else $error("8x8 product wrong");

  c_div_done: cover property (o_div_done);
  c_sub_borrow: cover property (o_result_valid && !o_status[0]);
  c_prio_locked: cover property (i_reg_wr && i_nesting_disable);
  c_window_hit: cover property (o_window_hit);
endmodule

// file: testbench/cas_seq_model.sv
// Sequencer model that issues divides and keeps copies of the two work registers.
`timescale 1ns/10ps
module cas_seq_model (
  input wire logic i_sys_clk, // Core clock
  input wire logic i_go, // Issue one divide
  input wire logic i_sgn, // Signed divide wanted
  input wire logic i_long, // 32-bit dividend wanted
  input wire logic [15:0] i_hi, // Dividend high word
  input wire logic [15:0] i_lo, // Dividend low word
  input wire logic [15:0] i_dvs, // Divisor
  input wire logic [3:0] i_stall, // Suspended cycles after start
  input wire logic i_div_done, // Done pulse from the datapath
  input wire logic [15:0] i_w0, // Quotient register
  input wire logic [15:0] i_w1, // Remainder register
  output logic o_div_start = 1'b0, // Divide start pulse
  output logic o_div_signed = 1'b0, // Signed divide
  output logic o_div_long = 1'b0, // 32-bit dividend
  output logic o_div_suspend = 1'b0, // Pause request
  output logic [15:0] o_div_hi = 16'h0000, // Dividend high word
  output logic [15:0] o_div_lo = 16'h0000, // Dividend low word
  output logic [15:0] o_divisor = 16'h0000, // Divisor
  output logic o_seen = 1'b0, // Divide finished and captured
  output logic [15:0] o_q = 16'h0000, // Captured quotient
  output logic [15:0] o_r = 16'h0000, // Captured remainder
  output logic [7:0] o_cycles = 8'h00 // Edges from start to done
);
  logic run = 1'b0;
  logic [3:0] hold = 4'h0;
  logic [7:0] cnt = 8'h00;
  // Operands stay put until the next divide, as a register file would hold them.
  always @(posedge i_sys_clk) begin
    o_div_start <= i_go;
    if (i_go) begin
      o_div_signed <= i_sgn;
      o_div_long <= i_long;
      o_div_hi <= i_hi;
      o_div_lo <= i_lo;
      o_divisor <= i_dvs;
      o_seen <= 1'b0;
      run <= 1'b0;
    end else if (o_div_start) begin
      run <= 1'b1;
      cnt <= 8'h00;
      hold <= i_stall;
      o_div_suspend <= (i_stall != 4'h0);
    end else if (run) begin
      cnt <= cnt + 8'h01;
      if (hold != 4'h0) begin
        hold <= hold - 4'h1;
      end
      o_div_suspend <= (hold > 4'h1);
      if (i_div_done) begin
        run <= 1'b0;
        o_seen <= 1'b1;
        o_cycles <= cnt;
        o_q <= i_w0;
        o_r <= i_w1;
      end
    end
  end
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the CPU ALU status datapath.
`timescale 1ns/10ps
module tb_top;
  import cas_pkg::*;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic i_op_valid = 1'b0, i_op_byte = 1'b0, i_mul_a_signed = 1'b0, i_mul_b_signed = 1'b0;
  logic i_loop_active = 1'b0, i_nesting_disable = 1'b0, i_prio_load = 1'b0;
  logic i_prio_top_set = 1'b0, i_pc_load = 1'b0, i_pc_step = 1'b0;
  logic [1:0] i_reg_addr = 2'h0;
  logic [3:0] i_prio_value = 4'h0;
  logic [7:0] i_table_page = 8'h00, i_window_page = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000, i_op_a = 16'h0000, i_op_b = 16'h0000;
  logic [15:0] i_table_offset = 16'h0000, i_data_ea = 16'h0000;
  logic [22:0] i_pc_value = 23'h000000;
  cas_op_t i_op_code = OP_ADD;
  cas_asel_t i_addr_sel = AS_PC;
  logic i_div_start, i_div_signed, i_div_long, i_div_suspend;
  logic [15:0] i_div_hi, i_div_lo, i_divisor, o_reg_rdata, o_result, o_status, o_control;
  logic [15:0] o_work_reg_zero, o_work_reg_one;
  logic [31:0] o_product;
  logic o_result_valid, o_user_irq_block, o_prog_window_enable, o_div_busy, o_div_done;
  logic o_window_hit, o_config_space;
  logic [3:0] o_cpu_priority;
  logic [23:0] o_prog_addr;
  logic go = 1'b0, sgn = 1'b0, lng = 1'b0, seen;
  logic [3:0] stall = 4'h0;
  logic [15:0] d_hi = 16'h0000, d_lo = 16'h0000, dvs = 16'h0001, q, r;
  logic [7:0] cycles;
  int n_mismatch = 0;
  int checks_done = 0;

  cas_datapath dut_u (.i_sys_clk, .i_reset, .i_clk_en, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_op_valid, .i_op_code, .i_op_byte, .i_mul_a_signed,
    .i_mul_b_signed, .i_op_a, .i_op_b, .o_result, .o_product, .o_result_valid, .i_loop_active,
    .i_nesting_disable, .i_prio_load, .i_prio_value, .i_prio_top_set, .o_status, .o_control,
    .o_cpu_priority, .o_user_irq_block, .o_prog_window_enable, .i_div_start, .i_div_signed,
    .i_div_long, .i_div_suspend, .i_div_hi, .i_div_lo, .i_divisor, .o_work_reg_zero,
    .o_work_reg_one, .o_div_busy, .o_div_done, .i_pc_load, .i_pc_step, .i_pc_value, .i_addr_sel,
    .i_table_page, .i_table_offset, .i_window_page, .i_data_ea, .o_prog_addr, .o_window_hit,
    .o_config_space);
  cas_seq_model seq_u (.i_sys_clk, .i_go(go), .i_sgn(sgn), .i_long(lng), .i_hi(d_hi),
    .i_lo(d_lo), .i_dvs(dvs), .i_stall(stall), .i_div_done(o_div_done), .i_w0(o_work_reg_zero),
    .i_w1(o_work_reg_one), .o_div_start(i_div_start), .o_div_signed(i_div_signed),
    .o_div_long(i_div_long), .o_div_suspend(i_div_suspend), .o_div_hi(i_div_hi),
    .o_div_lo(i_div_lo), .o_divisor(i_divisor), .o_seen(seen), .o_q(q), .o_r(r),
    .o_cycles(cycles));

  always #50 i_sys_clk = ~i_sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 chk(o_reg_rdata, e, "register read");
  endtask
  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic t_reset();
    rd_chk(REG_STATUS, STATUS_RST);
    rd_chk(REG_CONTROL, CONTROL_RST);
    rd_chk(2'h2, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_regs();
    reg_wr(REG_STATUS, 16'hffff);
    rd_chk(REG_STATUS, 16'h01ef);
    i_nesting_disable <= 1'b1;
    reg_wr(REG_STATUS, 16'h0000);
    rd_chk(REG_STATUS, 16'h00e0);
    chk(o_cpu_priority, 4'h7, "priority");
    chk(o_user_irq_block, 1'b1, "block at level 7");
    reg_wr(REG_CONTROL, 16'hffff);
    rd_chk(REG_CONTROL, 16'h0004);
    chk(o_prog_window_enable, 1'b1, "window enable");
    @(posedge i_sys_clk);
    i_prio_top_set <= 1'b1;
    @(posedge i_sys_clk);
    i_prio_top_set <= 1'b0;
    #1 chk(o_control, 16'h000c, "top bit set");
    chk(o_cpu_priority, 4'hf, "priority 15");
    reg_wr(REG_CONTROL, 16'h0000);
    rd_chk(REG_CONTROL, 16'h0000);
    i_nesting_disable <= 1'b0;
    i_prio_value <= 4'ha;
    i_prio_load <= 1'b1;
    @(posedge i_sys_clk);
    i_prio_load <= 1'b0;
    #1 chk(o_cpu_priority, 4'ha, "loaded priority");
    chk(o_user_irq_block, 1'b1, "block on top bit");
    reg_wr(REG_CONTROL, 16'h0000);
    i_loop_active <= 1'b1;
    reg_wr(REG_STATUS, 16'h0000);
    rd_chk(REG_STATUS, 16'h0010);
    chk(o_user_irq_block, 1'b0, "no block at level 0");
    i_loop_active <= 1'b0;
    settle();
    chk(o_status, 16'h0000, "loop flag low");
    $display("test registers done");
  endtask
  task automatic op(input cas_op_t c, input logic b8, input logic [1:0] sg, input logic [15:0] a,
                    input logic [15:0] b, input logic [31:0] ex, input logic [15:0] fl);
    @(posedge i_sys_clk);
    i_op_valid <= 1'b1;
    i_op_code <= c;
    i_op_byte <= b8;
    {i_mul_a_signed, i_mul_b_signed} <= sg;
    i_op_a <= a;
    i_op_b <= b;
    @(posedge i_sys_clk);
    i_op_valid <= 1'b0;
    #1 chk(o_result_valid, 1'b1, "result valid");
    chk(o_result, ex[15:0], "result");
    if (c == OP_MUL) begin
      chk(o_product, ex, "product");
    end
    chk(o_status & STATUS_SW_MASK, fl, "flags");
  endtask
  task automatic t_alu();
    op(OP_ADD, 1'b0, 2'h0, 16'h7fff, 16'h0001, 32'h8000, 16'h010c);
    op(OP_ADD, 1'b0, 2'h0, 16'hffff, 16'h0001, 32'h0000, 16'h0103);
    op(OP_SUB, 1'b0, 2'h0, 16'h0005, 16'h0005, 32'h0000, 16'h0103);
    op(OP_SUB, 1'b0, 2'h0, 16'h0000, 16'h0001, 32'hffff, 16'h0008);
    op(OP_ADD, 1'b1, 2'h0, 16'h120f, 16'h0001, 32'h1210, 16'h0100);
    op(OP_AND, 1'b0, 2'h0, 16'hf0f0, 16'h0f0f, 32'h0000, 16'h0102);
    op(OP_ADDC, 1'b0, 2'h0, 16'h0000, 16'h0000, 32'h0000, 16'h0002);
    op(OP_XOR, 1'b0, 2'h0, 16'h8000, 16'h0000, 32'h8000, 16'h0008);
    op(OP_SL, 1'b0, 2'h0, 16'h8001, 16'h0001, 32'h0002, 16'h0001);
    op(OP_ASR, 1'b0, 2'h0, 16'h8000, 16'h0004, 32'hf800, 16'h0009);
    op(OP_LSR, 1'b0, 2'h0, 16'h8000, 16'h000f, 32'h0001, 16'h0001);
    op(OP_SUBB, 1'b0, 2'h0, 16'h0003, 16'h0001, 32'h0002, 16'h0101);
    op(OP_MUL, 1'b0, 2'h3, 16'hffff, 16'h0002, 32'hfffffffe, 16'h0101);
    op(OP_MUL, 1'b1, 2'h0, 16'h12ff, 16'h34ff, 32'h0000fe01, 16'h0101);
    op(OP_MUL, 1'b0, 2'h1, 16'hffff, 16'hffff, 32'hffff0001, 16'h0101);
    op(OP_MUL, 1'b0, 2'h2, 16'hfffe, 16'h001f, 32'hffffffc2, 16'h0101);
    op(OP_IOR, 1'b0, 2'h0, 16'h0000, 16'h0000, 32'h0000, 16'h0103);
    $display("test alu done");
  endtask
  task automatic dv(input logic s, input logic l, input logic [15:0] h, input logic [15:0] lo,
                    input logic [15:0] d, input logic [3:0] st, input logic [31:0] qr);
    int k;
    int nb;
    @(posedge i_sys_clk);
    sgn <= s;
    lng <= l;
    d_hi <= h;
    d_lo <= lo;
    dvs <= d;
    stall <= st;
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    #1 k = 0;
    nb = 0;
    while (seen !== 1'b1 && k < 100) begin
      @(posedge i_sys_clk);
      #1 k++;
      if (o_div_busy === 1'b1) begin
        nb++;
      end
    end
    chk(nb, {27'h0, DIV_CYCLES} + {28'h0, st}, "busy cycles");
    chk(q, qr[31:16], "quotient");
    chk(r, qr[15:0], "remainder");
    chk(cycles, {3'h0, DIV_CYCLES} + {4'h0, st}, "divide cycles");
  endtask
  task automatic t_div();
    dv(1'b0, 1'b1, 16'h0001, 16'h0000, 16'h0007, 4'h0, 32'h24920002);
    dv(1'b1, 1'b0, 16'ha5a5, 16'hfff9, 16'h0002, 4'h3, 32'hfffdffff);
    dv(1'b1, 1'b1, 16'hffff, 16'hff9c, 16'h0007, 4'h0, 32'hfff2fffe);
    dv(1'b0, 1'b0, 16'h5a5a, 16'h0064, 16'h000a, 4'h1, 32'h000a0000);
    $display("test divide done");
  endtask
  task automatic t_addr();
    @(posedge i_sys_clk);
    i_pc_value <= 23'h012344;
    i_pc_load <= 1'b1;
    @(posedge i_sys_clk);
    i_pc_load <= 1'b0;
    settle();
    chk(o_prog_addr, 24'h012344, "pc address");
    i_pc_step <= 1'b1;
    @(posedge i_sys_clk);
    i_pc_step <= 1'b0;
    settle();
    chk(o_prog_addr, 24'h012346, "pc step");
    i_addr_sel <= AS_TABLE;
    i_table_page <= 8'h80;
    i_table_offset <= 16'h0010;
    settle();
    chk({o_config_space, o_prog_addr}, {1'b1, 24'h800010}, "config table");
    i_table_page <= 8'h7f;
    settle();
    chk({o_config_space, o_prog_addr}, {1'b0, 24'h7f0010}, "user table");
    reg_wr(REG_CONTROL, 16'h0004);
    i_addr_sel <= AS_WINDOW;
    i_window_page <= 8'h05;
    i_data_ea <= 16'h8123;
    settle();
    chk({o_window_hit, o_prog_addr}, {1'b1, 24'h028123}, "window hit");
    i_data_ea <= 16'h0123;
    settle();
    chk(o_window_hit, 1'b0, "lower half");
    i_data_ea <= 16'h8123;
    reg_wr(REG_CONTROL, 16'h0000);
    settle();
    chk(o_window_hit, 1'b0, "window off");
    // A low clock enable must hold the program counter and address output still.
    @(posedge i_sys_clk);
    i_addr_sel <= AS_PC;
    settle();
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    i_pc_step <= 1'b1;
    settle();
    chk(o_prog_addr, 24'h012346, "frozen by clock enable");
    @(posedge i_sys_clk);
    i_pc_step <= 1'b0;
    i_clk_en <= 1'b1;
    settle();
    chk(o_prog_addr, 24'h012346, "no step after enable");
    $display("test addresses done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The tests need well under a thousand cycles; the limit leaves ample margin.
  initial begin
    #(5000 * 100);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    t_reset();
    t_regs();
    t_alu();
    t_div();
    t_addr();
    tally_and_finish();
  end
endmodule
